// ### rtl/bst_tap.sv
// boundary-scan test logic: tap state machine and the four test registers
// assumes the test pins arrive asynchronously and are sampled on core_clk_i;
// the test clock must be several core clocks per phase.
`timescale 1ns/1ps
module bst_tap
   import bst_pkg::*;
(
   // system
   input  wire logic                  core_clk_i,
   input  wire logic                  sys_rst_i,
   // test pins
   input  wire logic                  tck_i,
   input  wire logic                  tms_i,
   input  wire logic                  tdi_i,
   output logic                       tdo_o,
   output logic                       tdo_oe_o,
   // function pins seen by the boundary cells
   input  wire logic [7:0]            pin_in_i,
   input  wire logic [1:0]            pin_oe_i,
   input  wire logic [7:0]            core_out_i,
   // state shown to the device
   output logic                       test_mode_o,
   output logic [`BST_IR_W-1:0]       instr_o,
   output logic [`BST_BSR_W-1:0]      bound_latch_o,
   output logic [`BST_CTL_W-1:0]      ctrl_latch_o,
   output logic                       in_reset_o
);

   // ***********************************************************
   // input synchronisers
   // ***********************************************************
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic       tck_d_r;
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;
   logic [1:0] oe_s1_r;
   logic [1:0] oe_s2_r;

   // two flops each; only sync2 is read by logic
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_r  <= `BST_PIN_IDLE; // tck low, tms/tdi high: no false edge after reset
         sync2_r  <= `BST_PIN_IDLE;
         tck_d_r  <= 1'h0;
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         oe_s1_r  <= 2'h3;
         oe_s2_r  <= 2'h3;
      end else begin
         sync1_r  <= {tck_i, tms_i, tdi_i};
         sync2_r  <= sync1_r;
         tck_d_r  <= sync2_r[2];
         pin_s1_r <= pin_in_i;
         pin_s2_r <= pin_s1_r;
         oe_s1_r  <= pin_oe_i;
         oe_s2_r  <= oe_s1_r;
      end
   end

   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic rise;
   logic fall;
   assign tck_s = sync2_r[2];
   assign tms_s = sync2_r[1];
   assign tdi_s = sync2_r[0];
   assign rise  = tck_s & ~tck_d_r;
   assign fall  = ~tck_s & tck_d_r;

   // ***********************************************************
   // tap state machine
   // ***********************************************************
   bst_state_t state_r;
   bst_state_t state_nxt;

   // standard sixteen-state walk; tms high reaches reset in five steps
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RESET:    state_nxt = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE:     state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR:   state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR:   state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:    state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR:   state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: state_nxt = tms_s ? ST_EX2_DR : ST_PAUSE_DR;
         ST_EX2_DR:   state_nxt = tms_s ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR:   state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR:   state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR:   state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:    state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR:   state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: state_nxt = tms_s ? ST_EX2_IR : ST_PAUSE_IR;
         ST_EX2_IR:   state_nxt = tms_s ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR:   state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      endcase
   end

   // power-up lands in test-logic-reset
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_RESET;
      end else if (rise) begin
         state_r <= state_nxt;
      end
   end

   // ***********************************************************
   // instruction decode
   // ***********************************************************
   logic [`BST_IR_W-1:0] ir_sh_r;
   logic [`BST_IR_W-1:0] ir_lat_r;

   // selected data register; anything unlisted falls to bypass
   function automatic bst_dr_sel_t dr_of(input logic [`BST_IR_W-1:0] op);
      case (op)
         `BST_OP_EXTEST, `BST_OP_SAMPLE, `BST_OP_INTEST, `BST_OP_READBN,
         `BST_OP_READBT, `BST_OP_CELLTST: dr_of = DR_BOUND;
         `BST_OP_SCANCN, `BST_OP_SCANCT:  dr_of = DR_CTRL;
         default:                          dr_of = DR_BYPASS;
      endcase
   endfunction

   // test mode per opcode; odd-parity or unknown codes stay normal
   function automatic logic mode_of(input logic [`BST_IR_W-1:0] op);
      case (op)
         `BST_OP_EXTEST, `BST_OP_INTEST, `BST_OP_HIGHZ, `BST_OP_CLAMP, `BST_OP_RUN_TEST,
         `BST_OP_READBT, `BST_OP_TOGGLE, `BST_OP_SCANCT: mode_of = 1'b1;
         default:                                         mode_of = 1'b0;
      endcase
   endfunction

   bst_dr_sel_t dr_sel;
   assign dr_sel = dr_of(ir_lat_r);

   // ***********************************************************
   // instruction register: shift stage and shadow latch
   // ***********************************************************
   // capture on exit edge, shift lsb first, hold in pause
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ir_sh_r <= `BST_IR_RST;
      end else if (rise) begin
         if (state_r == ST_RESET) begin
            ir_sh_r <= `BST_IR_RST;
         end else if (state_r == ST_CAP_IR) begin
            ir_sh_r <= `BST_IR_CAPT;
         end else if (state_r == ST_SH_IR) begin
            ir_sh_r <= {tdi_s, ir_sh_r[`BST_IR_W-1:1]};
         end
      end
   end

   // shadow latch; parity bit 7 is taken as shifted, the controller keeps it even
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ir_lat_r <= `BST_IR_RST;
      end else if (state_r == ST_RESET) begin
         ir_lat_r <= `BST_IR_RST;
      end else if (fall && state_r == ST_UPD_IR) begin
         ir_lat_r <= ir_sh_r;
      end
   end

   // ***********************************************************
   // data registers
   // ***********************************************************
   logic [`BST_BSR_W-1:0] bsr_sh_r;
   logic [`BST_BSR_W-1:0] bsr_lat_r;
   logic [`BST_CTL_W-1:0] ctl_sh_r;
   logic [`BST_CTL_W-1:0] ctl_lat_r;
   logic                  byp_r;
   logic [`BST_BSR_W-1:0] bsr_capt;

   // capture image in chain order: oe 17-16, inputs 15-8, outputs 7-0
   assign bsr_capt = {oe_s2_r, pin_s2_r, core_out_i};

   // extest, sample and intest capture the same pin image; read and self test keep the cells
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bsr_sh_r <= `BST_BSR_RST;
      end else if (state_r == ST_RESET) begin
         bsr_sh_r <= `BST_BSR_RST;
      end else if (rise && dr_sel == DR_BOUND) begin
         if (state_r == ST_CAP_DR && ir_lat_r != `BST_OP_READBN && ir_lat_r != `BST_OP_READBT
             && ir_lat_r != `BST_OP_CELLTST) begin
            bsr_sh_r <= bsr_capt;
         end else if (state_r == ST_SH_DR) begin
            bsr_sh_r <= {tdi_s, bsr_sh_r[`BST_BSR_W-1:1]};
         end
      end
   end

   // boundary-control shift stage never captures
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_sh_r <= `BST_CTL_RST;
      end else if (state_r == ST_RESET) begin
         ctl_sh_r <= `BST_CTL_RST;
      end else if (rise && dr_sel == DR_CTRL && state_r == ST_SH_DR) begin
         ctl_sh_r <= {tdi_s, ctl_sh_r[`BST_CTL_W-1:1]};
      end
   end

   // bypass: one stage, zero on capture, no shadow
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         byp_r <= 1'b0;
      end else if (rise && dr_sel == DR_BYPASS) begin
         if (state_r == ST_CAP_DR) begin
            byp_r <= 1'b0;
         end else if (state_r == ST_SH_DR) begin
            byp_r <= tdi_s;
         end
      end
   end

   // run-test pattern step on the boundary latches while idle under run test
   function automatic logic [7:0] lfsr_step(input logic [7:0] v);
      lfsr_step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   logic [2:0] ctl_op;
   logic [7:0] in_mask;
   logic       run_act;
   assign ctl_op  = ctl_lat_r[`BST_CTL_OP_MSB:`BST_CTL_OP_LSB];
   assign in_mask = {ctl_lat_r[`BST_CTL_M2_LSB +: 4], ctl_lat_r[`BST_CTL_M1_LSB +: 4]};
   // one step per tck rise: the controller sets the run length by how long it idles
   assign run_act = rise && state_r == ST_IDLE && ir_lat_r == `BST_OP_RUN_TEST;

   // boundary shadow: update-dr loads, run test alters in idle
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bsr_lat_r <= `BST_BSR_RST;
      end else if (state_r == ST_RESET) begin
         bsr_lat_r <= `BST_BSR_RST;
      end else if (fall && state_r == ST_UPD_DR && dr_sel == DR_BOUND) begin
         bsr_lat_r <= bsr_sh_r;
      end else if (run_act) begin
         // op codes: 0 toggle, 1 pattern, 2 signature, 3 signature+pattern, 4 signature+count
         if (ctl_op == 3'h2 || ctl_op == 3'h3 || ctl_op == 3'h4) begin
            bsr_lat_r[`BST_BSR_IN_LSB +: 8] <= lfsr_step(bsr_lat_r[`BST_BSR_IN_LSB +: 8]) ^ (pin_s2_r & ~in_mask);
         end
         if (ctl_op == 3'h0) begin
            bsr_lat_r[`BST_BSR_OUT_LSB +: 8] <= ~bsr_lat_r[`BST_BSR_OUT_LSB +: 8];
         end else if (ctl_op == 3'h1 || ctl_op == 3'h3) begin
            bsr_lat_r[`BST_BSR_OUT_LSB +: 8] <= lfsr_step(bsr_lat_r[`BST_BSR_OUT_LSB +: 8]);
         end else if (ctl_op == 3'h4) begin
            bsr_lat_r[`BST_BSR_OUT_LSB +: 8] <= bsr_lat_r[`BST_BSR_OUT_LSB +: 8] + 8'h01;
         end
      end
   end

   // boundary-control shadow
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_lat_r <= `BST_CTL_RST;
      end else if (state_r == ST_RESET) begin
         ctl_lat_r <= `BST_CTL_RST;
      end else if (fall && state_r == ST_UPD_DR && dr_sel == DR_CTRL) begin
         ctl_lat_r <= ctl_sh_r;
      end
   end

   // ***********************************************************
   // serial output, falling edge only
   // ***********************************************************
   logic dr_bit;
   always_comb begin
      unique case (dr_sel)
         DR_BOUND: dr_bit = bsr_sh_r[0];
         DR_CTRL:  dr_bit = ctl_sh_r[0];
         default:  dr_bit = byp_r;
      endcase
   end

   // drive only in shift states; exit1 turns off on its first falling edge
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (fall) begin
         if (state_r == ST_SH_IR) begin
            tdo_o    <= ir_sh_r[0];
            tdo_oe_o <= 1'b1;
         end else if (state_r == ST_SH_DR) begin
            tdo_o    <= dr_bit;
            tdo_oe_o <= 1'b1;
         end else begin
            tdo_oe_o <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // registered status outputs
   // ***********************************************************
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         test_mode_o   <= 1'b0;
         instr_o       <= `BST_IR_RST;
         bound_latch_o <= `BST_BSR_RST;
         ctrl_latch_o  <= `BST_CTL_RST;
         in_reset_o    <= 1'b1;
      end else begin
         test_mode_o   <= mode_of(ir_lat_r) && state_r != ST_RESET;
         instr_o       <= ir_lat_r;
         bound_latch_o <= bsr_lat_r;
         ctrl_latch_o  <= ctl_lat_r;
         in_reset_o    <= state_r == ST_RESET;
      end
   end

endmodule

// ### rtl/bst_defines.svh
// constants for the boundary-scan test logic: state codes live in the package,
// here are register widths, reset values, opcodes and field positions.
// assumes inclusion by bare name from the package, the checker and the bench.
// ***********************************************************************
// ***********************************************************************
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_IR_W        8
`define BST_BSR_W       18
`define BST_CTL_W       11
`define BST_IR_RST      8'hFF
`define BST_IR_CAPT     8'h81
`define BST_BSR_RST     18'h30000
`define BST_CTL_RST     11'h002
`define BST_PIN_IDLE    3'h3
`define BST_OP_EXTEST   8'h00
`define BST_OP_SAMPLE   8'h82
`define BST_OP_INTEST   8'h03
`define BST_OP_HIGHZ    8'h06
`define BST_OP_CLAMP    8'h87
`define BST_OP_RUN_TEST 8'h09
`define BST_OP_READBN   8'h0A
`define BST_OP_READBT   8'h8B
`define BST_OP_CELLTST  8'h0C
`define BST_OP_TOGGLE   8'h8D
`define BST_OP_SCANCN   8'h8E
`define BST_OP_SCANCT   8'h0F
`define BST_CTL_OP_LSB  0
`define BST_CTL_OP_MSB  2
`define BST_CTL_M1_LSB  3
`define BST_CTL_M2_LSB  7
`define BST_BSR_OE2     17
`define BST_BSR_OE1     16
`define BST_BSR_IN_LSB  8
`define BST_BSR_OUT_LSB 0
`define BST_TRST_TMS_N  5
`endif

// ### rtl/bst_pkg.sv
// types for the boundary-scan test logic
// assumes the defines header sits beside it
package bst_pkg;
   `include "bst_defines.svh"
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
   } bst_state_t;
   typedef enum logic [1:0] {
      DR_BYPASS, DR_BOUND, DR_CTRL
   } bst_dr_sel_t;
endpackage

// ### verif/bst_tap_asserts.sv
// checker on the ports of the boundary-scan tap block
// assumes bst_defines.svh on the include path and tck phases of 4 core clocks
`timescale 1ns/1ps
`include "bst_defines.svh"
module bst_tap_asserts
   import bst_pkg::*;
(
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   // test pins
   input wire logic        tck_i,
   input wire logic        tms_i,
   input wire logic        tdo_o,
   input wire logic        tdo_oe_o,
   // latched state
   input wire logic        test_mode_o,
   input wire logic [7:0]  instr_o,
   input wire logic [17:0] bound_latch_o,
   input wire logic [10:0] ctrl_latch_o,
   input wire logic        in_reset_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ****************************************
   // helper: rises of tck seen with tms high
   // ****************************************
   logic       tck_r;
   logic [2:0] hi_cnt_r;
   logic       tcode;
   assign tcode = instr_o inside {8'h00, 8'h03, 8'h06, 8'h87, 8'h09, 8'h8B, 8'h8D, 8'h0F};
   // saturates at five so the count never wraps
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tck_r    <= 1'b0;
         hi_cnt_r <= 3'h0;
      end else begin
         tck_r <= tck_i;
         if (tck_i && !tck_r) begin
            hi_cnt_r <= !tms_i ? 3'h0 : (hi_cnt_r == 3'h5 ? 3'h5 : hi_cnt_r + 3'h1);
         end
      end
   end
   sequence s_tdo_hold;
      $stable({tdo_o, tdo_oe_o})[*3];
   endsequence
   sequence s_tlr_seen;
      ##[0:6] in_reset_o;
   endsequence
   // depth 3 looks back past the sync delay to the tck phase that caused a change
   AST_TDO_FALL_ONLY: assert property ($rose(tck_i) |=> s_tdo_hold)
      else $error("tdo moved after a tck rise");
   AST_OE_ON: assert property ($rose(tdo_oe_o) |-> !$past(tck_i, 3))
      else $error("tdo enabled off a falling edge");
   AST_OE_OFF: assert property ($fell(tdo_oe_o) |-> !$past(tck_i, 3))
      else $error("tdo released off a falling edge");
   AST_IR_UPD: assert property ($changed(instr_o) && instr_o != `BST_IR_RST |-> !$past(tck_i, 3))
      else $error("instruction latched off a falling edge");
   AST_CTRL_UPD: assert property ($changed(ctrl_latch_o) && ctrl_latch_o != `BST_CTL_RST |-> !$past(tck_i, 3))
      else $error("control latch loaded off a falling edge");
   AST_BOUND_UPD: assert property ($changed(bound_latch_o) && bound_latch_o != `BST_BSR_RST
      && instr_o != `BST_OP_RUN_TEST |-> !$past(tck_i, 3))
      else $error("boundary latch loaded off a falling edge");
   AST_IR_RST: assert property (in_reset_o && $past(in_reset_o) |-> instr_o == `BST_IR_RST)
      else $error("instruction not forced in reset");
   AST_BSR_RST: assert property (in_reset_o && $past(in_reset_o) |-> bound_latch_o == `BST_BSR_RST)
      else $error("boundary cells not reset");
   AST_CTL_RST: assert property (in_reset_o && $past(in_reset_o) |-> ctrl_latch_o == `BST_CTL_RST)
      else $error("control register not reset");
   AST_TLR_QUIET: assert property (in_reset_o && $past(in_reset_o) |-> !test_mode_o && !tdo_oe_o)
      else $error("test logic active in reset");
   AST_MODE: assert property (test_mode_o |-> tcode || $past(tcode))
      else $error("test mode with a normal instruction");
   AST_TLR5: assert property (hi_cnt_r == 3'h5 |-> s_tlr_seen)
      else $error("five high tms rises missed reset");
endmodule
bind bst_tap bst_tap_asserts bst_tap_asserts_inst (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i),
   .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .test_mode_o(test_mode_o), .instr_o(instr_o),
   .bound_latch_o(bound_latch_o), .ctrl_latch_o(ctrl_latch_o), .in_reset_o(in_reset_o)
);

// ### verif/bst_ctl_model.sv
// model of the four-wire test bus controller
// assumes pins are moved at core clock falling edges, tck period 8 core clocks
`timescale 1ns/1ps
module bst_ctl_model (
   // pacing clock
   input  wire logic core_clk_i,
   // serial answer
   input  wire logic tdo_i,
   // test pins
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o
);
   // ****************************************
   // pin steps
   // ****************************************
   // tck stands low between frames; tms and tdi rest high like the pull-ups
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // one tck period: set pins in low phase, take tdo mid high phase
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      repeat (4) @(negedge core_clk_i);
      tck_o = 1'b1;
      repeat (2) @(negedge core_clk_i);
      tdo = tdo_i;
      repeat (2) @(negedge core_clk_i);
      tck_o = 1'b0;
   endtask
   // five high tms rises; ends in test-logic-reset
   task automatic tlr();
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
   endtask
   // full scan from idle back to idle; lsb first, optional pause after bit p
   task automatic scan(input logic ir, input int n, input int p, input logic [31:0] din, output logic [31:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b1, b);
      if (ir) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == p, din[i], dout[i]);
         if (i == p) begin
            repeat (2) step(1'b0, 1'b1, b); // linger in pause
            step(1'b1, 1'b1, b);
            step(1'b0, 1'b1, b); // back to shift without capture
         end
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask
endmodule

// ### verif/bst_tap_tb.sv
// self-checking bench for the boundary-scan tap block
// assumes bst_defines.svh on the include path
`timescale 1ns/1ps
`include "bst_defines.svh"
module bst_tap_tb
   import bst_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i  = 1'b1;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo_o;
   logic        tdo_oe_o;
   logic [7:0]  pin_in_i   = 8'h3C;
   logic [1:0]  pin_oe_i   = 2'h2;
   logic [7:0]  core_out_i = 8'hA5;
   logic        test_mode_o;
   logic [7:0]  instr_o;
   logic [17:0] bound_latch_o;
   logic [10:0] ctrl_latch_o;
   logic        in_reset_o;
   int          errors     = 0;
   int          n_compared = 0;
   always #50 core_clk_i = ~core_clk_i;
   bst_tap bst_tap_inst (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i), .pin_oe_i(pin_oe_i),
      .core_out_i(core_out_i), .test_mode_o(test_mode_o), .instr_o(instr_o),
      .bound_latch_o(bound_latch_o), .ctrl_latch_o(ctrl_latch_o), .in_reset_o(in_reset_o)
   );
   // tdo has no pull-up: a released pin shows the inverse so a read outside shift fails
   bst_ctl_model bst_ctl_model_inst (
      .core_clk_i(core_clk_i), .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
   );
   // ****************************************
   // compare and close
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog: the run needs about 0.13 ms
   initial begin
      #1000000;
      errors++;
      complete_run();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [31:0] d;
      logic        b;
      repeat (20) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      check("instr", instr_o, `BST_IR_RST);
      check("bound", bound_latch_o, `BST_BSR_RST);
      check("ctrl", ctrl_latch_o, `BST_CTL_RST);
      check("reset", {in_reset_o, test_mode_o, tdo_oe_o}, 3'h4);
      bst_ctl_model_inst.step(1'b0, 1'b1, b);
      // opcodes below all carry even parity in bit 7
      bst_ctl_model_inst.scan(1'b1, 8, -1, `BST_OP_SCANCN, d);
      check("ir_out", d, 32'h81);
      check("instr", instr_o, `BST_OP_SCANCN);
      check("mode", test_mode_o, 1'b0);
      // control scan with a pause mid-way; the old value must come out intact
      bst_ctl_model_inst.scan(1'b0, 11, 4, 32'h5A5, d);
      check("ctrl_out", d, 32'h002);
      check("ctrl", ctrl_latch_o, 11'h5A5);
      bst_ctl_model_inst.scan(1'b1, 8, -1, `BST_OP_SCANCT, d);
      check("mode", test_mode_o, 1'b1);
      // unsupported opcode, paused in the instruction scan
      bst_ctl_model_inst.scan(1'b1, 8, 2, 32'h05, d);
      check("ir_out", d, 32'h81);
      check("mode", test_mode_o, 1'b0);
      bst_ctl_model_inst.scan(1'b0, 3, -1, 32'h5, d);
      check("bypass_out", d, 32'h2);
      check("ctrl", ctrl_latch_o, 11'h5A5);
      // sample: one extra bit proves the chain length
      bst_ctl_model_inst.scan(1'b1, 8, -1, `BST_OP_SAMPLE, d);
      bst_ctl_model_inst.scan(1'b0, 19, -1, 32'h5698F, d);
      check("bound_out", d, 32'h63CA5);
      check("bound", bound_latch_o, 18'h2B4C7);
      // run test with control op 0 flips the output cells once per idle rise
      bst_ctl_model_inst.scan(1'b1, 8, -1, `BST_OP_SCANCN, d);
      bst_ctl_model_inst.scan(1'b0, 11, -1, 32'h000, d);
      check("ctrl_out", d, 32'h5A5);
      check("ctrl", ctrl_latch_o, 11'h000);
      bst_ctl_model_inst.scan(1'b1, 8, -1, `BST_OP_RUN_TEST, d);
      bst_ctl_model_inst.step(1'b0, 1'b1, b);
      check("mode", test_mode_o, 1'b1);
      check("bound", bound_latch_o, 18'h2B438);
      bst_ctl_model_inst.tlr();
      repeat (4) @(negedge core_clk_i);
      check("in_reset", in_reset_o, 1'b1);
      check("instr", instr_o, `BST_IR_RST);
      check("bound", bound_latch_o, `BST_BSR_RST);
      check("ctrl", ctrl_latch_o, `BST_CTL_RST);
      complete_run();
   end
endmodule
